// ==== design/mid_defs.vh ====
// constants for the instruction decoder: register port offsets,
// configuration fields, cycle counts, operation codes and flag positions.
// assumes inclusion by bare name from the design files.
`ifndef MID_DEFS_VH
`define MID_DEFS_VH

// ************************************************************
// register port
// ************************************************************
`define MID_CFG_ADDR   4'h0
`define MID_STAT_ADDR  4'h1
`define MID_WORD_ADDR  4'h2
`define MID_CFG_RST    13'h0000
`define MID_CFG_CLKS   10
`define MID_RD_ZERO    16'h0000

// ************************************************************
// instruction word and cycle timing
// ************************************************************
`define MID_IW         13
`define MID_TC_TWO     2'h1
`define MID_TC_FOUR    2'h3
`define MID_PC_REG     6'h02

// ************************************************************
// flag mask positions
// ************************************************************
`define MID_FZ   0
`define MID_FC   1
`define MID_FDC  2
`define MID_FT   3
`define MID_FP   4

// ************************************************************
// operation codes
// ************************************************************
`define MID_OP_NOP    6'h00
`define MID_OP_DAA    6'h01
`define MID_OP_CTLW   6'h02
`define MID_OP_SLEEP  6'h03
`define MID_OP_CLEAR_WATCHDOG   6'h04
`define MID_OP_IOW    6'h05
`define MID_OP_ENI    6'h06
`define MID_OP_INTERRUPT_DISABLE_OP   6'h07
`define MID_OP_RET    6'h08
`define MID_OP_RETURN_ENABLE_IRQ   6'h09
`define MID_OP_CTLR   6'h0A
`define MID_OP_IOR    6'h0B
`define MID_OP_TBL    6'h0C
`define MID_OP_MOVRA  6'h0D
`define MID_OP_CLR    6'h0E
`define MID_OP_SUB    6'h0F
`define MID_OP_DEC    6'h10
`define MID_OP_OR     6'h11
`define MID_OP_AND    6'h12
`define MID_OP_XOR    6'h13
`define MID_OP_ADD    6'h14
`define MID_OP_MOV    6'h15
`define MID_OP_COM    6'h16
`define MID_OP_INC    6'h17
`define MID_OP_DJZ    6'h18
`define MID_OP_RRC    6'h19
`define MID_OP_RLC    6'h1A
`define MID_OP_SWAP   6'h1B
`define MID_OP_JZ     6'h1C
`define MID_OP_BC     6'h1D
`define MID_OP_BS     6'h1E
`define MID_OP_JBC    6'h1F
`define MID_OP_JBS    6'h20
`define MID_OP_CALL   6'h21
`define MID_OP_JMP    6'h22
`define MID_OP_MOVK   6'h23
`define MID_OP_ORK    6'h24
`define MID_OP_ANDK   6'h25
`define MID_OP_XORK   6'h26
`define MID_OP_RETL   6'h27
`define MID_OP_SUBK   6'h28
`define MID_OP_INT    6'h29
`define MID_OP_ADDK   6'h2A

`endif

// ==== design/mid_cycle_timer.v ====
// instruction cycle timer: one pulse per instruction cycle.
// assumes ref_clk is the oscillator and four_clk is a same-clock level.
`timescale 1ns/10ps
`default_nettype none
`include "mid_defs.vh"

module mid_cycle_timer (
   input  wire       ref_clk,
   input  wire       rstn,
   input  wire       four_clk,
   input  wire       run,
   output reg        cyc_end
);

   reg  [1:0] cnt_reg;
   wire [1:0] term;

   assign term = four_clk ? `MID_TC_FOUR : `MID_TC_TWO;

   // ************************************************************
   // oscillator period counter
   // ************************************************************
   // a length change takes effect at once, mid cycle: the running count is compared against the new terminal count
   always @(posedge ref_clk) begin
      if (!rstn) begin
         cnt_reg <= 2'h0;
         cyc_end <= 1'b0;
      end else if (!run) begin
         cnt_reg <= 2'h0;
         cyc_end <= 1'b0;
      end else if (cnt_reg >= term) begin
         cnt_reg <= 2'h0;
         cyc_end <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         cyc_end <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ==== design/mid_decoder.v ====
// instruction decoder with cycle timing and a small register port.
// assumes program memory on ref_clk presents a word for each fetch,
// and an asynchronous wake pin that ends sleep.
`timescale 1ns/10ps
`default_nettype none
`include "mid_defs.vh"

module mid_decoder (
   input  wire        ref_clk,
   input  wire        rstn,
   input  wire [12:0] instr_word,
   input  wire        instr_valid,
   input  wire        wake_pin,
   input  wire [3:0]  sw_addr,
   input  wire [15:0] sw_wdata,
   input  wire        sw_wr,
   input  wire        sw_rd,
   output reg  [15:0] sw_rdata,
   output reg         fetch_req,
   output reg         exec_strobe,
   output reg  [5:0]  op_code,
   output reg         dest_is_reg,
   output reg  [5:0]  reg_addr,
   output reg  [2:0]  bit_sel,
   output reg  [3:0]  io_addr,
   output reg  [7:0]  lit8,
   output reg  [9:0]  lit10,
   output reg  [4:0]  flag_mask,
   output reg         pd_flag_val,
   output reg         wdt_clear,
   output reg         stack_push,
   output reg         stack_pop,
   output reg         two_cycle,
   output reg         irq_enable,
   output reg         osc_stop
);

   // ************************************************************
   // state and wires
   // ************************************************************
   reg  [12:0] cfg_reg;
   reg  [12:0] word_reg;
   reg         wake_s1_reg;
   reg         wake_s2_reg;
   reg         stall_reg;
   reg  [5:0]  op_next;
   reg         dst_next;
   reg  [4:0]  flg_next;
   reg         pcw_next;
   wire        cyc_end;
   wire        take;
   wire [12:0] w;

   assign w    = instr_word;
   assign take = cyc_end & ~stall_reg & instr_valid;

   // ************************************************************
   // instruction cycle timer
   // ************************************************************
   mid_cycle_timer u_timer (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .four_clk (cfg_reg[`MID_CFG_CLKS]),
      .run      (~osc_stop),
      .cyc_end  (cyc_end)
   );

   // ************************************************************
   // decode
   // ************************************************************
   always @* begin
      op_next  = `MID_OP_NOP;
      dst_next = 1'b0;
      flg_next = 5'h00;
      if (!w[12]) begin
         if (w[11:8] == 4'h0) begin
            if (w[7:5] == 3'h0) begin
               // fixed codes are listed first so they win
               case (w[4:0])
                  5'h00: begin
                     op_next = `MID_OP_NOP;
                  end
                  5'h01: begin
                     op_next = `MID_OP_DAA;
                     flg_next[`MID_FC] = 1'b1;
                  end
                  5'h02: begin
                     op_next = `MID_OP_CTLW;
                  end
                  5'h03: begin
                     op_next = `MID_OP_SLEEP;
                     flg_next[`MID_FT] = 1'b1;
                     flg_next[`MID_FP] = 1'b1;
                  end
                  5'h04: begin
                     op_next = `MID_OP_CLEAR_WATCHDOG;
                     flg_next[`MID_FT] = 1'b1;
                     flg_next[`MID_FP] = 1'b1;
                  end
                  5'h10: begin
                     op_next = `MID_OP_ENI;
                  end
                  5'h11: begin
                     op_next = `MID_OP_INTERRUPT_DISABLE_OP;
                  end
                  5'h12: begin
                     op_next = `MID_OP_RET;
                  end
                  5'h13: begin
                     op_next = `MID_OP_RETURN_ENABLE_IRQ;
                  end
                  5'h14: begin
                     op_next = `MID_OP_CTLR;
                  end
                  default: begin
                     if (!w[4]) begin
                        op_next = `MID_OP_IOW;
                     end else begin
                        op_next = `MID_OP_IOR;
                     end
                  end
               endcase
            end else if (w[7:0] == 8'h20) begin
               op_next  = `MID_OP_TBL;
               flg_next = 5'h07;
            end else if (w[7:6] == 2'h1) begin
               op_next  = `MID_OP_MOVRA;
               dst_next = 1'b1;
            end else if (w[7:6] == 2'h2) begin
               op_next  = `MID_OP_CLR;
               flg_next[`MID_FZ] = 1'b1;
            end else if (w[7:6] == 2'h3) begin
               op_next  = `MID_OP_CLR;
               dst_next = 1'b1;
               flg_next[`MID_FZ] = 1'b1;
            end
         end else if (!w[11]) begin
            // row and bit 7 pick the operation, bit 6 the destination
            dst_next = w[6];
            case ({w[10:8], w[7]})
               4'h2: begin
                  op_next  = `MID_OP_SUB;
                  flg_next = 5'h07;
               end
               4'h3: begin
                  op_next  = `MID_OP_DEC;
                  flg_next = 5'h01;
               end
               4'h4: begin
                  op_next  = `MID_OP_OR;
                  flg_next = 5'h01;
               end
               4'h5: begin
                  op_next  = `MID_OP_AND;
                  flg_next = 5'h01;
               end
               4'h6: begin
                  op_next  = `MID_OP_XOR;
                  flg_next = 5'h01;
               end
               4'h7: begin
                  op_next  = `MID_OP_ADD;
                  flg_next = 5'h07;
               end
               4'h8: begin
                  op_next  = `MID_OP_MOV;
                  flg_next = 5'h01;
               end
               4'h9: begin
                  op_next  = `MID_OP_COM;
                  flg_next = 5'h01;
               end
               4'hA: begin
                  op_next  = `MID_OP_INC;
                  flg_next = 5'h01;
               end
               4'hB: begin
                  op_next  = `MID_OP_DJZ;
               end
               4'hC: begin
                  op_next  = `MID_OP_RRC;
                  flg_next = 5'h02;
               end
               4'hD: begin
                  op_next  = `MID_OP_RLC;
                  flg_next = 5'h02;
               end
               4'hE: begin
                  op_next  = `MID_OP_SWAP;
               end
               default: begin
                  op_next  = `MID_OP_JZ;
               end
            endcase
         end else begin
            case (w[10:9])
               2'h0: begin
                  op_next  = `MID_OP_BC;
                  dst_next = 1'b1;
               end
               2'h1: begin
                  op_next  = `MID_OP_BS;
                  dst_next = 1'b1;
               end
               2'h2: begin
                  op_next  = `MID_OP_JBC;
               end
               default: begin
                  op_next  = `MID_OP_JBS;
               end
            endcase
         end
      end else if (!w[11]) begin
         if (w[10]) begin
            op_next = `MID_OP_JMP;
         end else begin
            op_next = `MID_OP_CALL;
         end
      end else begin
         case (w[10:8])
            3'h0: begin
               op_next  = `MID_OP_MOVK;
            end
            3'h1: begin
               op_next  = `MID_OP_ORK;
               flg_next = 5'h01;
            end
            3'h2: begin
               op_next  = `MID_OP_ANDK;
               flg_next = 5'h01;
            end
            3'h3: begin
               op_next  = `MID_OP_XORK;
               flg_next = 5'h01;
            end
            3'h4: begin
               op_next  = `MID_OP_RETL;
            end
            3'h5: begin
               op_next  = `MID_OP_SUBK;
               flg_next = 5'h07;
            end
            3'h6: begin
               if (w[7:0] == 8'h01) begin
                  op_next = `MID_OP_INT;
               end
            end
            default: begin
               op_next  = `MID_OP_ADDK;
               flg_next = 5'h07;
            end
         endcase
      end
      // a register write landing on the program counter costs a cycle
      pcw_next = (dst_next & (w[5:0] == `MID_PC_REG))
               | (op_next == `MID_OP_TBL);
   end

   // ************************************************************
   // wake pin synchroniser
   // ************************************************************
   always @(posedge ref_clk) begin
      if (!rstn) begin
         wake_s1_reg <= 1'b0;
         wake_s2_reg <= 1'b0;
      end else begin
         wake_s1_reg <= wake_pin;
         wake_s2_reg <= wake_s1_reg;
      end
   end

   // ************************************************************
   // decoded outputs, one set per instruction cycle that takes a word
   // ************************************************************
   always @(posedge ref_clk) begin
      if (!rstn) begin
         exec_strobe <= 1'b0;
         op_code     <= `MID_OP_NOP;
         dest_is_reg <= 1'b0;
         reg_addr    <= 6'h00;
         bit_sel     <= 3'h0;
         io_addr     <= 4'h0;
         lit8        <= 8'h00;
         lit10       <= 10'h000;
         flag_mask   <= 5'h00;
         two_cycle   <= 1'b0;
         word_reg    <= 13'h0000;
         stall_reg   <= 1'b0;
      end else begin
         exec_strobe <= take;
         if (take) begin
            op_code     <= op_next;
            dest_is_reg <= dst_next;
            reg_addr    <= w[5:0];
            bit_sel     <= w[8:6];
            io_addr     <= w[3:0];
            lit8        <= w[7:0];
            lit10       <= w[9:0];
            flag_mask   <= flg_next;
            two_cycle   <= pcw_next;
            word_reg    <= w;
            stall_reg   <= pcw_next;
         end else if (cyc_end) begin
            // the stall cycle executes nothing and fetches nothing
            stall_reg <= 1'b0;
         end
      end
   end

   // ************************************************************
   // side effects: fetch, watchdog, stack, interrupts, sleep
   // ************************************************************
   always @(posedge ref_clk) begin
      if (!rstn) begin
         fetch_req   <= 1'b0;
         wdt_clear   <= 1'b0;
         pd_flag_val <= 1'b1;
         stack_push  <= 1'b0;
         stack_pop   <= 1'b0;
         irq_enable  <= 1'b0;
         osc_stop    <= 1'b0;
      end else begin
         fetch_req  <= take;
         wdt_clear  <= take & ((op_next == `MID_OP_SLEEP)
                     | (op_next == `MID_OP_CLEAR_WATCHDOG));
         stack_push <= take & ((op_next == `MID_OP_CALL)
                     | (op_next == `MID_OP_INT));
         stack_pop  <= take & ((op_next == `MID_OP_RET)
                     | (op_next == `MID_OP_RETURN_ENABLE_IRQ)
                     | (op_next == `MID_OP_RETL));
         if (take && op_next == `MID_OP_SLEEP) begin
            pd_flag_val <= 1'b0;
         end else if (take && op_next == `MID_OP_CLEAR_WATCHDOG) begin
            pd_flag_val <= 1'b1;
         end
         if (take && (op_next == `MID_OP_ENI
                   || op_next == `MID_OP_RETURN_ENABLE_IRQ)) begin
            irq_enable <= 1'b1;
         end else if (take && op_next == `MID_OP_INTERRUPT_DISABLE_OP) begin
            irq_enable <= 1'b0;
         end
         // wake is a level; a pin held high makes sleep a one-cycle pause
         if (take && op_next == `MID_OP_SLEEP) begin
            osc_stop <= 1'b1;
         end else if (wake_s2_reg) begin
            osc_stop <= 1'b0;
         end
      end
   end

   // ************************************************************
   // register port
   // ************************************************************
   always @(posedge ref_clk) begin
      if (!rstn) begin
         cfg_reg  <= `MID_CFG_RST;
         sw_rdata <= `MID_RD_ZERO;
      end else begin
         if (sw_wr && sw_addr == `MID_CFG_ADDR) begin
            cfg_reg <= sw_wdata[12:0];
         end
         if (!sw_rd) begin
            sw_rdata <= `MID_RD_ZERO;
         end else if (sw_addr == `MID_CFG_ADDR) begin
            sw_rdata <= {3'h0, cfg_reg};
         end else if (sw_addr == `MID_STAT_ADDR) begin
            sw_rdata <= {7'h00, irq_enable, osc_stop, stall_reg, op_code};
         end else if (sw_addr == `MID_WORD_ADDR) begin
            sw_rdata <= {3'h0, word_reg};
         end else begin
            sw_rdata <= `MID_RD_ZERO;
         end
      end
   end

endmodule
`default_nettype wire

// ==== test/mid_prog_mem.sv ====
// program memory model: hands the decoder one word per fetch.
// assumes the decoder's fetch_req pulse, on the same clock.
`timescale 1ns/10ps
`default_nettype none
module mid_prog_mem (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        fetch_req,
   output logic      [12:0] instr_word,
   output logic             instr_valid
);
   // ************************************************************
   // word supply
   // ************************************************************
   logic [12:0] rom [0:31];
   int          len = 0;
   logic [5:0]  pc;
   logic [5:0]  addr;
   // look ahead on fetch_req so the next word is ready at the next cycle end
   assign addr        = pc + {5'h00, fetch_req};
   assign instr_valid = addr < len;
   // past the program the bus shows the inverse, never a stale word
   assign instr_word  = instr_valid ? rom[addr[4:0]] : ~rom[addr[4:0]];
   always @(posedge ref_clk) begin
      if (!rstn)
         pc <= 6'h00;
      else
         pc <= addr;
   end
endmodule
`default_nettype wire

// ==== test/mid_decoder_asserts.sv ====
// assertions on the decoder's ports: pulses, stalls, sleep, flag masks.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "mid_defs.vh"
module mid_decoder_asserts (
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic [12:0] instr_word,
   input wire logic        exec_strobe,
   input wire logic        fetch_req,
   input wire logic [5:0]  op_code,
   input wire logic [5:0]  reg_addr,
   input wire logic [2:0]  bit_sel,
   input wire logic [7:0]  lit8,
   input wire logic [4:0]  flag_mask,
   input wire logic        pd_flag_val,
   input wire logic        wdt_clear,
   input wire logic        stack_pop,
   input wire logic        two_cycle,
   input wire logic        irq_enable,
   input wire logic        osc_stop
);
   // ************************************************************
   // checks
   // ************************************************************
   logic [12:0] word_d;
   always @(posedge ref_clk) word_d <= instr_word;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   exec_pulse_a: assert property (exec_strobe |=> !exec_strobe)
      else $error("exec strobe longer than one cycle");
   fetch_pair_a: assert property (exec_strobe == fetch_req)
      else $error("fetch request and exec strobe disagree");
   field_split_a: assert property (exec_strobe |-> reg_addr == word_d[5:0] &&
      bit_sel == word_d[8:6] && lit8 == word_d[7:0]) else $error("operand fields wrong");
   pc_stall_a: assert property (exec_strobe && two_cycle |=> !exec_strobe [*3])
      else $error("no stall after program counter write");
   sleep_enter_a: assert property (exec_strobe && op_code == `MID_OP_SLEEP |->
      osc_stop && !pd_flag_val && wdt_clear && flag_mask == 5'h18) else $error("sleep wrong");
   wdt_clear_a: assert property (exec_strobe && op_code == `MID_OP_CLEAR_WATCHDOG |->
      wdt_clear && pd_flag_val && !osc_stop) else $error("watchdog clear wrong");
   sleep_halt_a: assert property (osc_stop |=> !exec_strobe)
      else $error("instruction taken while asleep");
   irq_on_a: assert property (exec_strobe && (op_code == `MID_OP_ENI ||
      op_code == `MID_OP_RETURN_ENABLE_IRQ) |-> irq_enable) else $error("interrupts not enabled");
   irq_off_a: assert property (exec_strobe && op_code == `MID_OP_INTERRUPT_DISABLE_OP |-> !irq_enable)
      else $error("interrupts not disabled");
   stack_pop_a: assert property (stack_pop |-> exec_strobe && (op_code == `MID_OP_RET ||
      op_code == `MID_OP_RETURN_ENABLE_IRQ || op_code == `MID_OP_RETL)) else $error("stray stack pop");
   sub_flags_a: assert property (exec_strobe && op_code == `MID_OP_SUB |->
      flag_mask == 5'h07) else $error("subtract flag mask wrong");
   move_flags_a: assert property (exec_strobe && (op_code == `MID_OP_MOVRA ||
      op_code == `MID_OP_CTLW || op_code == `MID_OP_IOR) |-> flag_mask == 5'h00)
      else $error("move changes flags");
   sleep_c: cover property (exec_strobe && op_code == `MID_OP_SLEEP);
   stall_c: cover property (exec_strobe && two_cycle);
   pop_c: cover property (stack_pop);
endmodule
bind mid_decoder mid_decoder_asserts chk_i (.ref_clk(ref_clk), .rstn(rstn),
   .instr_word(instr_word), .exec_strobe(exec_strobe), .fetch_req(fetch_req),
   .op_code(op_code), .reg_addr(reg_addr), .bit_sel(bit_sel), .lit8(lit8),
   .flag_mask(flag_mask), .pd_flag_val(pd_flag_val), .wdt_clear(wdt_clear),
   .stack_pop(stack_pop), .two_cycle(two_cycle), .irq_enable(irq_enable),
   .osc_stop(osc_stop));
`default_nettype wire

// ==== test/mcu_instruction_decoder_test.sv ====
// testbench for the instruction decoder with a program memory model.
// assumes the bound checker and the constants header.
`timescale 1ns/10ps
`default_nettype none
`include "mid_defs.vh"
module mcu_instruction_decoder_test;
   // ************************************************************
   // harness
   // ************************************************************
   logic        ref_clk, rstn, wake_pin, sw_wr, sw_rd, instr_valid;
   logic [3:0]  sw_addr;
   logic [15:0] sw_wdata, sw_rdata;
   logic [12:0] instr_word;
   logic [5:0]  op_code, reg_addr;
   logic [2:0]  bit_sel;
   logic [3:0]  io_addr;
   logic [7:0]  lit8;
   logic [9:0]  lit10;
   logic [4:0]  flag_mask;
   logic        fetch_req, exec_strobe, dest_is_reg, pd_flag_val, wdt_clear;
   logic        stack_push, stack_pop, two_cycle, irq_enable, osc_stop;
   int          bad_count = 0, n_checks = 0, cyc = 0;
   logic [12:0] cw [0:29] = '{13'h0000, 13'h0001, 13'h0002, 13'h0004, 13'h0005, 13'h0010,
      13'h0011, 13'h0012, 13'h0013, 13'h0014, 13'h001F, 13'h0045, 13'h0080, 13'h00C5,
      13'h0105, 13'h0145, 13'h0185, 13'h01C5, 13'h0205, 13'h0245, 13'h0285, 13'h02C5,
      13'h0305, 13'h0345, 13'h09FF, 13'h0AD0, 13'h0C45, 13'h0E85, 13'h13FF, 13'h18A5};
   logic [5:0]  co [0:29] = '{`MID_OP_NOP, `MID_OP_DAA, `MID_OP_CTLW, `MID_OP_CLEAR_WATCHDOG,
      `MID_OP_IOW, `MID_OP_ENI, `MID_OP_INTERRUPT_DISABLE_OP, `MID_OP_RET, `MID_OP_RETURN_ENABLE_IRQ, `MID_OP_CTLR,
      `MID_OP_IOR, `MID_OP_MOVRA, `MID_OP_CLR, `MID_OP_CLR, `MID_OP_SUB, `MID_OP_SUB,
      `MID_OP_DEC, `MID_OP_DEC, `MID_OP_OR, `MID_OP_OR, `MID_OP_AND, `MID_OP_AND,
      `MID_OP_XOR, `MID_OP_XOR, `MID_OP_BC, `MID_OP_BS, `MID_OP_JBC, `MID_OP_JBS,
      `MID_OP_CALL, `MID_OP_MOVK};
   logic [4:0]  cm [0:29] = '{5'h00, 5'h02, 5'h00, 5'h18, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
      5'h00, 5'h00, 5'h00, 5'h01, 5'h01, 5'h07, 5'h07, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01,
      5'h01, 5'h01, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
   mid_prog_mem mem (.ref_clk(ref_clk), .rstn(rstn), .fetch_req(fetch_req),
      .instr_word(instr_word), .instr_valid(instr_valid));
   mid_decoder uut (.ref_clk(ref_clk), .rstn(rstn), .instr_word(instr_word),
      .instr_valid(instr_valid), .wake_pin(wake_pin), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
      .fetch_req(fetch_req), .exec_strobe(exec_strobe), .op_code(op_code),
      .dest_is_reg(dest_is_reg), .reg_addr(reg_addr), .bit_sel(bit_sel), .io_addr(io_addr),
      .lit8(lit8), .lit10(lit10), .flag_mask(flag_mask), .pd_flag_val(pd_flag_val),
      .wdt_clear(wdt_clear), .stack_push(stack_push), .stack_pop(stack_pop),
      .two_cycle(two_cycle), .irq_enable(irq_enable), .osc_stop(osc_stop));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // a hang costs at most a few thousand cycles before the report
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         end_of_test();
      end
   end
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_wdata <= v;
      sw_wr <= 1'b1;
      @(posedge ref_clk);
      sw_wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge ref_clk);
      sw_rd <= 1'b0;
      @(posedge ref_clk);
      v = sw_rdata;
   endtask
   task automatic restart();
      @(posedge ref_clk);
      rstn <= 1'b0;
      mem.len <= 0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
   endtask
   task automatic next_exec(output int g);
      g = 0;
      do begin
         @(posedge ref_clk);
         g++;
      end while (exec_strobe !== 1'b1 && g < 60);
      if (g >= 60) chk("exec_wait", 16'h0001, 16'h0000);
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_codes();
      int          g;
      logic [15:0] d;
      restart();
      for (int i = 0; i < 30; i++) mem.rom[i] = cw[i];
      mem.len <= 30;
      for (int i = 0; i < 30; i++) begin
         next_exec(g);
         chk("op_code", {10'h000, co[i]}, {10'h000, op_code});
         chk("flag_mask", {11'h000, cm[i]}, {11'h000, flag_mask});
         if (i > 0) chk("gap", 16'h0002, 16'(g));
         if (i > 10) chk("reg_addr", {10'h000, cw[i][5:0]}, {10'h000, reg_addr});
         if (i > 10 && i < 24) chk("dest", {15'h0000, cw[i][6]}, {15'h0000, dest_is_reg});
         if (i > 23 && i < 28) chk("bit_sel", {13'h0000, cw[i][8:6]}, {13'h0000, bit_sel});
         if (i == 4) chk("io_addr", 16'h0005, {12'h000, io_addr});
         if (i == 28) chk("lit10", 16'h03FF, {6'h00, lit10});
         if (i == 28) chk("push", 16'h0001, {15'h0000, stack_push});
         if (i == 29) chk("lit8", 16'h00A5, {8'h00, lit8});
      end
      bus_rd(`MID_WORD_ADDR, d);
      chk("word", 16'h18A5, d);
      bus_rd(4'h7, d);
      chk("unmapped", 16'h0000, d);
   endtask
   task automatic t_timing(input logic four);
      int          g, c;
      logic [15:0] d;
      c = four ? 4 : 2;
      restart();
      // store accumulator into the program counter register: a two-cycle write
      mem.rom[0] = 13'h0042;
      mem.rom[1] = 13'h0000;
      mem.rom[2] = 13'h00C2;
      mem.rom[3] = 13'h0000;
      bus_wr(`MID_CFG_ADDR, {5'h00, four, 10'h000});
      bus_rd(`MID_CFG_ADDR, d);
      chk("cfg", {5'h00, four, 10'h000}, d);
      mem.len <= 4;
      next_exec(g);
      chk("two_cycle", 16'h0001, {15'h0000, two_cycle});
      for (int k = 0; k < 3; k++) begin
         next_exec(g);
         chk("gap", 16'((k == 1) ? c : 2 * c), 16'(g));
      end
   endtask
   task automatic t_sleep();
      int g;
      restart();
      mem.rom[0] = 13'h0003;
      mem.rom[1] = 13'h0004;
      mem.len <= 2;
      next_exec(g);
      chk("sleep_op", {10'h000, `MID_OP_SLEEP}, {10'h000, op_code});
      chk("sleep_st", 16'h0005, {13'h0000, osc_stop, pd_flag_val, wdt_clear});
      // nothing may execute while the oscillator is stopped
      g = 0;
      repeat (12) begin
         @(posedge ref_clk);
         if (exec_strobe !== 1'b0) g++;
      end
      chk("halted", 16'h0000, 16'(g));
      wake_pin <= 1'b1;
      next_exec(g);
      chk("woken", 16'h0001, {15'h0000, g < 12});
      chk("clear_watchdog_op", {10'h000, `MID_OP_CLEAR_WATCHDOG}, {10'h000, op_code});
      chk("clear_watchdog_st", 16'h0003, {13'h0000, osc_stop, pd_flag_val, wdt_clear});
      wake_pin <= 1'b0;
   endtask
   initial begin
      rstn = 1'b0;
      wake_pin = 1'b0;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      sw_addr = 4'h0;
      sw_wdata = 16'h0000;
      repeat (5) @(posedge ref_clk);
      t_codes();
      t_timing(1'b0);
      t_timing(1'b1);
      t_sleep();
      end_of_test();
   end
endmodule
`default_nettype wire
